// ---- rtl/urxs_pkg.sv ----
// shared constants, types and helpers of the receive status block
// assumes a 32-bit register bus with byte addresses on word boundaries
package urxs_pkg;

  // register byte offsets
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFS_INT_EN  = 8'h18;
  localparam logic [7:0]  OFS_PEEK    = 8'h1C;
  localparam logic [7:0]  OFS_POP     = 8'h20;

  // enable bit positions in the low half of the enable register
  localparam int unsigned BIT_ROLE_FAULT = 1;
  localparam int unsigned BIT_DUAL_ROLE  = 2;
  localparam int unsigned BIT_FRAME      = 3;
  localparam int unsigned BIT_RX_NE      = 4;
  localparam int unsigned BIT_NP_TX_E    = 5;
  localparam int unsigned BIT_NP_IN_NAK  = 6;
  localparam int unsigned BIT_OUT_NAK    = 7;
  localparam int unsigned BIT_EARLY_SUSP = 10;
  localparam int unsigned EN_W           = 11;

  // which enable bits each role may touch
  localparam logic [EN_W-1:0] EN_BOTH     = 11'h01E;
  localparam logic [EN_W-1:0] EN_HOST     = 11'h020;
  localparam logic [EN_W-1:0] EN_DEV      = 11'h4C0;
  localparam logic [EN_W-1:0] EN_RESET    = 11'h000;

  // status entry layout
  localparam int unsigned ENTRY_W    = 21;
  localparam int unsigned PKT_LSB    = 17;
  localparam int unsigned PID_LSB    = 15;
  localparam int unsigned BC_LSB     = 4;
  localparam int unsigned NUM_LSB    = 0;
  localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;

  // packet status codes
  localparam logic [3:0] ST_OUT_NAK     = 4'h1;
  localparam logic [3:0] ST_DATA_RX     = 4'h2;
  localparam logic [3:0] ST_XFER_DONE   = 4'h3;
  localparam logic [3:0] ST_SETUP_DONE  = 4'h4;
  localparam logic [3:0] ST_TOGGLE_ERR  = 4'h5;
  localparam logic [3:0] ST_SETUP_RX    = 4'h6;
  localparam logic [3:0] ST_CH_HALTED   = 4'h7;

  // data pid codes
  localparam logic [1:0] PID_DATA0 = 2'h0;
  localparam logic [1:0] PID_DATA1 = 2'h2;

  // bus answers and buffer depth
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int unsigned FIFO_DEPTH  = 2;

  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESP    = 1'b1
  } urxs_wr_e;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } urxs_rd_e;

  // enable bits reachable in the current role
  function automatic logic [EN_W-1:0] en_access(input logic host);
    en_access = EN_BOTH | (host ? EN_HOST : EN_DEV);
  endfunction

  // popped codes that raise an interrupt, per role
  function automatic logic pop_raises_irq(input logic       host,
                                          input logic [3:0] st);
    if (host) begin
      pop_raises_irq = (st == ST_XFER_DONE) || (st == ST_TOGGLE_ERR) ||
                       (st == ST_CH_HALTED);
    end else begin
      pop_raises_irq = (st == ST_OUT_NAK) || (st == ST_XFER_DONE) ||
                       (st == ST_SETUP_DONE);
    end
  endfunction

endpackage

// ---- rtl/urxs_fifo2.sv ----
// two-entry status buffer with valid/ready on both sides
// assumes one clock; the drain side may stall for any time
`timescale 1ns/1ps
module urxs_fifo2 import urxs_pkg::*; #(
  parameter int unsigned W     = ENTRY_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0]   count_q;
  logic          push;
  logic          pull;

  // full refuses the source, empty hides the head
  assign in_ready_o  = (count_q != FULL);
  assign out_valid_o = (count_q != '0);
  assign out_data_o  = mem_q[rd_ptr_q];
  assign push        = in_valid_i && in_ready_o;
  assign pull        = out_valid_o && out_ready_i;

  // storage written only on accepted words
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  // pointers wrap at the depth
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pull) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  // occupancy; push and pull together leave it unchanged
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
    end else if (push && !pull) begin
      count_q <= count_q + 1'b1;
    end else if (pull && !push) begin
      count_q <= count_q - 1'b1;
    end
  end
endmodule

// ---- rtl/urxs_irq_gate.sv ----
// gates interrupt source flags with their enables onto one line
// assumes flags are levels held by the flag register outside
`timescale 1ns/1ps
module urxs_irq_gate import urxs_pkg::*; (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            host_i,
  input  wire logic [EN_W-1:0] flags_i,
  input  wire logic [EN_W-1:0] en_i,
  output logic                 irq_o
);
  // inaccessible bits are masked so a stale enable from the
  // other role cannot leak an interrupt through
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flags_i & en_i & en_access(host_i));
    end
  end
endmodule

// ---- rtl/urxs_top.sv ----
// receive status access and low interrupt enables of the usb core
// assumes an AXI4-Lite master, a packet engine feeding status
// entries, and an external flag register holding source flags
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module urxs_top import urxs_pkg::*; (
  input  wire logic              CLK_I,
  input  wire logic              RST_N_I,
  // register bus
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  // current role of the core, 1 for host
  input  wire logic              HOST_MODE_I,
  // status entries from the packet engine
  input  wire logic              RX_ENTRY_VALID_I,
  output logic                   RX_ENTRY_READY_O,
  input  wire logic [3:0]        RX_PACKET_STATUS_I,
  input  wire logic [1:0]        RX_DATA_PID_I,
  input  wire logic [10:0]       RX_BYTE_COUNT_I,
  input  wire logic [3:0]        RX_CHANNEL_NUMBER_I,
  // source flags held by the flag register
  input  wire logic              EARLY_SUSPEND_FLAG_I,
  input  wire logic              OUT_NAK_EFFECTIVE_FLAG_I,
  input  wire logic              NP_IN_NAK_EFFECTIVE_FLAG_I,
  input  wire logic              NP_TX_FIFO_EMPTY_FLAG_I,
  input  wire logic              FRAME_START_FLAG_I,
  input  wire logic              DUAL_ROLE_EVENT_FLAG_I,
  input  wire logic              ROLE_FAULT_FLAG_I,
  // results
  output logic                   RX_FIFO_NOT_EMPTY_FLAG_O,
  output logic                   RX_POP_IRQ_EVENT_O,
  output logic                   ROLE_FAULT_EVENT_O,
  output logic                   CORE_IRQ_O
);

  // write channel state
  urxs_wr_e          wr_state_q;
  logic              aw_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_held_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic [1:0]        bresp_q;
  logic              do_write;
  logic              wr_full;
  logic              wr_en_hit;

  // read channel state
  urxs_rd_e          rd_state_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              ar_take;
  logic              pop;

  // enable register and events
  logic [EN_W-1:0]   int_en_q;
  logic [EN_W-1:0]   acc_mask;
  logic [EN_W-1:0]   src_flags;
  logic              pop_irq_q;
  logic              role_fault_q;
  logic              bad_bits;

  // status buffer ports
  logic [ENTRY_W-1:0] in_entry;
  logic [ENTRY_W-1:0] head_entry;
  logic               head_valid;
  logic [31:0]        head_word;

  // ------------------------------------------------------------
  // status entry path
  // ------------------------------------------------------------

  // fields packed in their final bit places so a read is a plain
  // zero extension; number means channel or endpoint by role
  assign in_entry = {RX_PACKET_STATUS_I,
                     RX_DATA_PID_I,
                     RX_BYTE_COUNT_I,
                     RX_CHANNEL_NUMBER_I};

  // two entries of slack so a slow reader loses no status word
  urxs_fifo2 #(
    .W     (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .rst_n_i     (RST_N_I),
    .in_valid_i  (RX_ENTRY_VALID_I),
    .in_ready_o  (RX_ENTRY_READY_O),
    .in_data_i   (in_entry),
    .out_valid_o (head_valid),
    .out_ready_i (pop),
    .out_data_o  (head_entry)
  );

  // upper bits read as zero; an empty buffer reads as the reset
  // value, since software is not meant to look before the flag
  assign head_word = head_valid ? {11'h000, head_entry}
                                : ENTRY_RESET;
  assign RX_FIFO_NOT_EMPTY_FLAG_O = head_valid;

  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------

  // address and data are taken in either order, one of each
  assign S_AXI_AWREADY_O = !aw_held_q && (wr_state_q == WR_COLLECT);
  assign S_AXI_WREADY_O  = !w_held_q && (wr_state_q == WR_COLLECT);
  assign do_write        = aw_held_q && w_held_q &&
                           (wr_state_q == WR_COLLECT);
  assign wr_full         = (w_strb_q == 4'hF);
  assign wr_en_hit       = (aw_addr_q == OFS_INT_EN) && wr_full;

  // address holding stage
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= S_AXI_AWADDR_I;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  // data holding stage
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_held_q <= 1'b1;
      w_data_q <= S_AXI_WDATA_I;
      w_strb_q <= S_AXI_WSTRB_I;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // response: only full-word writes to the enable register pass;
  // the status registers are read-only, the rest is unmapped
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_state_q <= WR_COLLECT;
      bresp_q    <= RESP_OKAY;
    end else begin
      case (wr_state_q)
        WR_COLLECT: begin
          if (do_write) begin
            wr_state_q <= WR_RESP;
            bresp_q    <= wr_en_hit ? RESP_OKAY : RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (S_AXI_BREADY_I) begin
            wr_state_q <= WR_COLLECT;
          end
        end
        default: begin
          wr_state_q <= WR_COLLECT;
        end
      endcase
    end
  end

  assign S_AXI_BVALID_O = (wr_state_q == WR_RESP);
  assign S_AXI_BRESP_O  = bresp_q;

  // ------------------------------------------------------------
  // enable register
  // ------------------------------------------------------------

  // bits the current role may reach; reserved bits never appear
  assign acc_mask = en_access(HOST_MODE_I);
  assign bad_bits = |(w_data_q[EN_W-1:0] & (EN_HOST | EN_DEV) &
                      ~acc_mask);

  // only reachable bits change, so the other role's settings
  // survive a role swap untouched
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      int_en_q <= EN_RESET;
    end else if (do_write && wr_en_hit) begin
      int_en_q <= (int_en_q & ~acc_mask) |
                  (w_data_q[EN_W-1:0] & acc_mask);
    end
  end

  // setting a bit of the other role is a role fault
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      role_fault_q <= 1'b0;
    end else begin
      role_fault_q <= do_write && wr_en_hit && bad_bits;
    end
  end

  assign ROLE_FAULT_EVENT_O = role_fault_q;

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------

  // one read under way; the answer comes one cycle after the take
  assign S_AXI_ARREADY_O = (rd_state_q == RD_IDLE);
  assign ar_take         = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign pop             = ar_take && head_valid &&
                           (S_AXI_ARADDR_I == OFS_POP);

  // read data captured at the take, before the pop moves the head
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (ar_take) begin
      case (S_AXI_ARADDR_I)
        OFS_INT_EN: begin
          rdata_q <= {21'h000000, int_en_q & acc_mask};
          rresp_q <= RESP_OKAY;
        end
        OFS_PEEK: begin
          rdata_q <= head_word;
          rresp_q <= RESP_OKAY;
        end
        OFS_POP: begin
          rdata_q <= head_word;
          rresp_q <= RESP_OKAY;
        end
        default: begin
          rdata_q <= '0;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end
  end

  // read answer holds until the master takes it
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_state_q <= RD_IDLE;
    end else begin
      case (rd_state_q)
        RD_IDLE: begin
          if (ar_take) begin
            rd_state_q <= RD_RESP;
          end
        end
        RD_RESP: begin
          if (S_AXI_RREADY_I) begin
            rd_state_q <= RD_IDLE;
          end
        end
        default: begin
          rd_state_q <= RD_IDLE;
        end
      endcase
    end
  end

  assign S_AXI_RVALID_O = (rd_state_q == RD_RESP);
  assign S_AXI_RDATA_O  = rdata_q;
  assign S_AXI_RRESP_O  = rresp_q;

  // ------------------------------------------------------------
  // events and interrupt line
  // ------------------------------------------------------------

  // popped status codes that call for attention, per role
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pop_irq_q <= 1'b0;
    end else begin
      pop_irq_q <= pop && pop_raises_irq(HOST_MODE_I,
                     head_entry[PKT_LSB +: 4]);
    end
  end

  assign RX_POP_IRQ_EVENT_O = pop_irq_q;

  // source flags gathered at their enable bit positions
  always_comb begin
    src_flags                 = '0;
    src_flags[BIT_ROLE_FAULT] = ROLE_FAULT_FLAG_I;
    src_flags[BIT_DUAL_ROLE]  = DUAL_ROLE_EVENT_FLAG_I;
    src_flags[BIT_FRAME]      = FRAME_START_FLAG_I;
    src_flags[BIT_RX_NE]      = head_valid;
    src_flags[BIT_NP_TX_E]    = NP_TX_FIFO_EMPTY_FLAG_I;
    src_flags[BIT_NP_IN_NAK]  = NP_IN_NAK_EFFECTIVE_FLAG_I;
    src_flags[BIT_OUT_NAK]    = OUT_NAK_EFFECTIVE_FLAG_I;
    src_flags[BIT_EARLY_SUSP] = EARLY_SUSPEND_FLAG_I;
  end

  // registered so the line is glitch free
  urxs_irq_gate u_irq (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .host_i  (HOST_MODE_I),
    .flags_i (src_flags),
    .en_i    (int_en_q),
    .irq_o   (CORE_IRQ_O)
  );

endmodule

// ---- tb/urxs_checker.sv ----
// port-level checks of the receive status and enable block
// assumes one clock domain and the active-low reset of the top
`timescale 1ns/1ps
module urxs_checker import urxs_pkg::*; (
  input wire logic              CLK_I,
  input wire logic              RST_N_I,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic              S_AXI_ARVALID_I,
  input wire logic              S_AXI_ARREADY_O,
  input wire logic [31:0]       S_AXI_RDATA_O,
  input wire logic              S_AXI_RVALID_O,
  input wire logic              S_AXI_RREADY_I,
  input wire logic [1:0]        S_AXI_BRESP_O,
  input wire logic              S_AXI_BVALID_O,
  input wire logic              S_AXI_BREADY_I,
  input wire logic              RX_ENTRY_VALID_I,
  input wire logic              RX_ENTRY_READY_O,
  input wire logic              EARLY_SUSPEND_FLAG_I,
  input wire logic              OUT_NAK_EFFECTIVE_FLAG_I,
  input wire logic              NP_IN_NAK_EFFECTIVE_FLAG_I,
  input wire logic              NP_TX_FIFO_EMPTY_FLAG_I,
  input wire logic              FRAME_START_FLAG_I,
  input wire logic              DUAL_ROLE_EVENT_FLAG_I,
  input wire logic              ROLE_FAULT_FLAG_I,
  input wire logic              RX_FIFO_NOT_EMPTY_FLAG_O,
  input wire logic              RX_POP_IRQ_EVENT_O,
  input wire logic              ROLE_FAULT_EVENT_O,
  input wire logic              CORE_IRQ_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // any source able to light the core line; enables are not visible
  wire logic src_any = EARLY_SUSPEND_FLAG_I | OUT_NAK_EFFECTIVE_FLAG_I |
    NP_IN_NAK_EFFECTIVE_FLAG_I | NP_TX_FIFO_EMPTY_FLAG_I |
    FRAME_START_FLAG_I | DUAL_ROLE_EVENT_FLAG_I | ROLE_FAULT_FLAG_I |
    RX_FIFO_NOT_EMPTY_FLAG_O;
  wire logic pop_hs = S_AXI_ARVALID_I && S_AXI_ARREADY_O &&
    (S_AXI_ARADDR_I == OFS_POP);

  read_answer_a: assert property (
    S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("read answer not one cycle after address");
  read_stand_a: assert property (
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
    S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read answer dropped or changed early");
  write_stand_a: assert property (
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
    S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write answer dropped or changed early");
  rsvd_zero_a: assert property (
    S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:21] == 11'h000)
    else $error("upper read bits not zero");
  entry_flag_a: assert property (
    RX_ENTRY_VALID_I && RX_ENTRY_READY_O |=> RX_FIFO_NOT_EMPTY_FLAG_O)
    else $error("stored entry not flagged");
  pop_drain_a: assert property (
    $fell(RX_FIFO_NOT_EMPTY_FLAG_O) |-> $past(pop_hs))
    else $error("buffer emptied without a pop");
  irq_cause_a: assert property (
    CORE_IRQ_O |-> src_any || $past(src_any))
    else $error("core line high with no source");
  pop_event_a: assert property (
    RX_POP_IRQ_EVENT_O |-> $past(pop_hs && RX_FIFO_NOT_EMPTY_FLAG_O))
    else $error("pop event without a pop");
  pop_pulse_a: assert property (
    RX_POP_IRQ_EVENT_O |=> !RX_POP_IRQ_EVENT_O)
    else $error("pop event longer than one cycle");
  fault_write_a: assert property (
    ROLE_FAULT_EVENT_O |-> S_AXI_BVALID_O || $past(S_AXI_BVALID_O))
    else $error("role fault event outside a write");

  pop_ev_c: cover property (RX_POP_IRQ_EVENT_O);
  fault_c: cover property (ROLE_FAULT_EVENT_O);
  full_c: cover property (RX_ENTRY_VALID_I && !RX_ENTRY_READY_O);
endmodule

// ---- tb/urxs_usb_partner.sv ----
// packet engine stand-in: hands received status entries to the block
// assumes send is called just after a rising clock edge
`timescale 1ns/1ps
module urxs_usb_partner (
  input  wire logic  clk_i,
  input  wire logic  ready_i,
  output logic       valid_o,
  output logic [3:0] st_o,
  output logic [1:0] pid_o,
  output logic [10:0] bc_o,
  output logic [3:0] num_o
);
  initial begin
    valid_o = 1'b0;
    {st_o, pid_o, bc_o, num_o} = 21'h000000;
  end
  // entry fields in wire order; gap models a slow engine
  task automatic send(input logic [20:0] e, input int gap);
    logic h;
    repeat (gap) @(posedge clk_i);
    valid_o <= 1'b1;
    {st_o, pid_o, bc_o, num_o} <= e;
    do begin
      @(negedge clk_i);
      h = ready_i;
      @(posedge clk_i);
    end while (!h);
    valid_o <= 1'b0;
    // released payload is not left looking valid
    {st_o, pid_o, bc_o, num_o} <= ~e;
  endtask
endmodule

// ---- tb/urxs_tb_top.sv ----
// self-checking bench of the receive status and enable block
// assumes the partner model feeds entries; bench is the bus master
`timescale 1ns/1ps
module urxs_tb_top import urxs_pkg::*;;
  `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    n_fail++; $display("Error %s exp %0h got %0h", n, e, g); end end
  logic clk = 1'b0, rst_n = 1'b0, host = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF, st, num;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic awr, wr, bv, arr, rv, rfe, ent_v, ent_r, ne, pop_ev, irq;
  logic [1:0] bresp, rresp, pid;
  logic [10:0] bc, flg = 11'h000;
  int n_fail = 0, tests_run = 0, cyc = 0, n_rf = 0;
  logic [31:0] d;
  logic [1:0] r;
  logic ev;
  logic [20:0] e;
  logic [4:0] cs[9] = '{5'h12, 5'h13, 5'h15, 5'h17, 5'h01, 5'h02,
                        5'h03, 5'h04, 5'h06};
  int bits[7] = '{10, 7, 6, 5, 3, 2, 1};

  always #4 clk = ~clk;
  urxs_top dut (.CLK_I(clk), .RST_N_I(rst_n),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(brdy), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rrdy), .HOST_MODE_I(host),
    .RX_ENTRY_VALID_I(ent_v), .RX_ENTRY_READY_O(ent_r),
    .RX_PACKET_STATUS_I(st), .RX_DATA_PID_I(pid), .RX_BYTE_COUNT_I(bc),
    .RX_CHANNEL_NUMBER_I(num), .EARLY_SUSPEND_FLAG_I(flg[10]),
    .OUT_NAK_EFFECTIVE_FLAG_I(flg[7]), .NP_IN_NAK_EFFECTIVE_FLAG_I(flg[6]),
    .NP_TX_FIFO_EMPTY_FLAG_I(flg[5]), .FRAME_START_FLAG_I(flg[3]),
    .DUAL_ROLE_EVENT_FLAG_I(flg[2]), .ROLE_FAULT_FLAG_I(flg[1]),
    .RX_FIFO_NOT_EMPTY_FLAG_O(ne), .RX_POP_IRQ_EVENT_O(pop_ev),
    .ROLE_FAULT_EVENT_O(rfe), .CORE_IRQ_O(irq));
  urxs_usb_partner usb (.clk_i(clk), .ready_i(ent_r), .valid_o(ent_v),
    .st_o(st), .pid_o(pid), .bc_o(bc), .num_o(num));

  // bus write; handshakes judged on values settled before the edge
  task automatic axw(input logic [7:0] a, input logic [31:0] dd,
                     input logic [3:0] s, output logic [1:0] rr);
    logic ha, hw, hb;
    awaddr <= a; wdata <= dd; wstrb <= s;
    awv <= 1'b1; wv <= 1'b1; brdy <= 1'b1;
    do begin
      @(negedge clk);
      ha = awv && awr; hw = wv && wr; hb = bv; rr = bresp;
      @(posedge clk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
    end while (!hb);
    brdy <= 1'b0;
    // one idle edge so a following call never re-raises it at once
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] dd,
                     output logic [1:0] rr, output logic pe);
    logic ha, hr;
    araddr <= a; arv <= 1'b1; rrdy <= 1'b1;
    do begin
      @(negedge clk);
      ha = arv && arr; hr = rv; dd = rdata; rr = rresp; pe = pop_ev;
      @(posedge clk);
      if (ha) arv <= 1'b0;
    end while (!hr);
    rrdy <= 1'b0;
    @(posedge clk);
  endtask
  // enable bits reachable in a role, worked out independently
  function automatic logic [10:0] reach(input logic h);
    return h ? 11'h03E : 11'h4DE;
  endfunction
  function automatic logic pop_irq(input logic h, input logic [3:0] c);
    return h ? (c == 4'h3 || c == 4'h5 || c == 4'h7)
             : (c == 4'h1 || c == 4'h3 || c == 4'h4);
  endfunction
  task automatic wrap_up;
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // role fault pulses, counted where settled
  always @(negedge clk) if (rfe === 1'b1) n_rf++;
  // hang guard well above the expected few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    void'($urandom(32'h7278));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axr(OFS_PEEK, d, r, ev);
    `CHK("empty peek", 32'h0, d)
    axr(OFS_INT_EN, d, r, ev);
    `CHK("enable reset", 32'h0, d)
    // role-limited writes; reserved bits stay zero
    for (int m = 1; m >= 0; m--) begin
      host <= m[0];
      d = $urandom | 32'h0000_04FE;
      axw(OFS_INT_EN, d, 4'hF, r);
      `CHK("enable write resp", RESP_OKAY, r)
      axr(OFS_INT_EN, d, r, ev);
      `CHK("enable read", {21'h0, reach(m[0])}, d)
    end
    `CHK("role fault", 2, n_rf)
    host <= 1'b1;
    axr(OFS_INT_EN, d, r, ev);
    `CHK("kept host bit", 32'h3E, d & 32'h3E)
    // refused accesses change nothing
    axw(OFS_PEEK, 32'hFFFF_FFFF, 4'hF, r);
    `CHK("write peek", RESP_SLVERR, r)
    axw(OFS_INT_EN, 32'h0, 4'h3, r);
    `CHK("partial write", RESP_SLVERR, r)
    axr(8'h44, d, r, ev);
    `CHK("unmapped read", RESP_SLVERR, r)
    // each external source flag lights the line only if enabled and reachable
    for (int m = 0; m < 2; m++) begin
      host <= m[0];
      foreach (bits[i]) begin
        axw(OFS_INT_EN, 32'h1 << bits[i], 4'hF, r);
        flg[bits[i]] <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        d = 32'(reach(m[0]));
        `CHK("gated irq", d[bits[i]], irq)
        @(posedge clk);
        axw(OFS_INT_EN, 32'h0, 4'hF, r);
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK("masked irq", 1'b0, irq)
        @(posedge clk);
        flg[bits[i]] <= 1'b0;
      end
    end
    // every status code, peeked then popped
    foreach (cs[i]) begin
      host <= cs[i][4];
      axw(OFS_INT_EN, 32'h10, 4'hF, r);
      e = {cs[i][3:0], ($urandom % 2) ? PID_DATA1 : PID_DATA0,
           11'($urandom), 4'($urandom)};
      usb.send(e, i % 3);
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK("non-empty flag", 1'b1, ne)
      `CHK("non-empty irq", 1'b1, irq)
      @(posedge clk);
      axr(OFS_PEEK, d, r, ev);
      `CHK("peek word", {11'h0, e}, d)
      axr(OFS_POP, d, r, ev);
      `CHK("pop word", {11'h0, e}, d)
      `CHK("pop event", pop_irq(cs[i][4], cs[i][3:0]), ev)
    end
    // fill until refused, then drain in order
    e = 21'($urandom);
    usb.send(e, 0);
    usb.send(~e, 1);
    @(negedge clk);
    `CHK("full refuses", 1'b0, ent_r)
    @(posedge clk);
    axr(OFS_POP, d, r, ev);
    `CHK("first out", {11'h0, e}, d)
    axr(OFS_POP, d, r, ev);
    `CHK("second out", {11'h0, ~e}, d)
    axr(OFS_POP, d, r, ev);
    `CHK("drained", 32'h0, d)
    wrap_up();
  end
endmodule

bind urxs_top urxs_checker chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
  .S_AXI_BREADY_I(S_AXI_BREADY_I), .RX_ENTRY_VALID_I(RX_ENTRY_VALID_I),
  .RX_ENTRY_READY_O(RX_ENTRY_READY_O),
  .EARLY_SUSPEND_FLAG_I(EARLY_SUSPEND_FLAG_I),
  .OUT_NAK_EFFECTIVE_FLAG_I(OUT_NAK_EFFECTIVE_FLAG_I),
  .NP_IN_NAK_EFFECTIVE_FLAG_I(NP_IN_NAK_EFFECTIVE_FLAG_I),
  .NP_TX_FIFO_EMPTY_FLAG_I(NP_TX_FIFO_EMPTY_FLAG_I),
  .FRAME_START_FLAG_I(FRAME_START_FLAG_I),
  .DUAL_ROLE_EVENT_FLAG_I(DUAL_ROLE_EVENT_FLAG_I),
  .ROLE_FAULT_FLAG_I(ROLE_FAULT_FLAG_I),
  .RX_FIFO_NOT_EMPTY_FLAG_O(RX_FIFO_NOT_EMPTY_FLAG_O),
  .RX_POP_IRQ_EVENT_O(RX_POP_IRQ_EVENT_O),
  .ROLE_FAULT_EVENT_O(ROLE_FAULT_EVENT_O), .CORE_IRQ_O(CORE_IRQ_O));
